// ---- design/pwmfdt_stage.sv ----
// pwm output stage: action generator, software forcing and dead time unit
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: up-down: A up sets, A down clears
// RULE2: up-count pulse placed between A and B
// RULE3: outputs follow own compares for dead band; here both share compares A and B, each with its own action table
// RULE4: one-time force acts now, later events act
// RULE5: held force ignores events until released
// RULE6: held force trigger: event or immediate
// RULE7: forcing enabled separately per output
// RULE8: both outputs derivable from first input
// RULE9: nine switches, every combination legal
// RULE10: both bypasses set pass inputs unchanged
// RULE11: inversion pair selects output polarity
// RULE12: first bypass: second is fall-delayed first
// RULE13: second bypass: first is rise-delayed first
// RULE14: select zero takes first input source
// RULE15: typical modes with select/swap/mode zero
// RULE16: separate 16-bit rise and fall counts
// RULE17: delay clock selects pwm or timer clock
// RULE18: delay counts shadowed to update point
// RULE19: whole dead time unit bypassable
// RULE20: set, clear, toggle, none per event
// RULE21: zero count passes edge undelayed
module pwmfdt_stage
  import pwmfdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] timer_count,
  input wire logic timer_count_up,
  input wire logic [15:0] timer_period_value,
  input wire logic timer_prescaled_clock,
  output logic pair_output_first,
  output logic pair_output_second
);
  import pwmfdt_pkg::*;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic apply_act(input logic cur, input logic [1:0] act);
    case (act)
      PWMFDT_ACT_LOW: apply_act = 1'b0;
      PWMFDT_ACT_HIGH: apply_act = 1'b1;
      PWMFDT_ACT_TOGGLE: apply_act = ~cur;
      default: apply_act = cur;
    endcase
  endfunction

  // picks the winning action of one output; later assignments win, so the
  // order below runs from lowest to highest priority per direction
  function automatic logic [1:0] pick_act(input logic [15:0] cfg, input logic up, input logic ez, input logic ep,
                                          input logic ea, input logic eb);
    logic [1:0] a;
    a = PWMFDT_ACT_NONE;
    if (up) begin
      if (ez) a = cfg[PWMFDT_ACT_UP_COUNT_ZERO_EVENT +: 2];
      if (ea) a = cfg[PWMFDT_ACT_UTEA +: 2];
      if (eb) a = cfg[PWMFDT_ACT_UTEB +: 2];
      if (ep) a = cfg[PWMFDT_ACT_UTEP +: 2];
    end else begin
      if (ep) a = cfg[PWMFDT_ACT_DTEP +: 2];
      if (ea) a = cfg[PWMFDT_ACT_DTEA +: 2];
      if (eb) a = cfg[PWMFDT_ACT_DTEB +: 2];
      if (ez) a = cfg[PWMFDT_ACT_DTEZ +: 2];
    end
    pick_act = a;
  endfunction

  // next count of an edge delay counter: runs while the input sits at the
  // level whose leading edge is delayed, saturating at the programmed count
  function automatic logic [15:0] dly_next(input logic [15:0] cnt, input logic run, input logic tick,
                                           input logic [15:0] lim);
    if (!run) dly_next = 16'h0000;
    else if (tick && cnt < lim) dly_next = cnt + 16'h0001;
    else dly_next = cnt;
  endfunction

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_b_q;
  logic [15:0] act_first_q;
  logic [15:0] act_second_q;
  logic [7:0] force_cfg_q;
  logic [11:0] dt_cfg_q;
  logic [15:0] rise_shadow_q;
  logic [15:0] fall_shadow_q;
  logic [15:0] rise_delay_count_q;
  logic [15:0] fall_delay_count_q;
  logic [1:0] held_force_q;
  logic [1:0] held_force_d;
  logic gen_first_q;
  logic gen_first_d;
  logic gen_second_q;
  logic gen_second_d;
  logic [15:0] rise_cnt_q;
  logic [15:0] rise_cnt_d;
  logic [15:0] fall_cnt_q;
  logic [15:0] fall_cnt_d;
  logic [15:0] rdata_d;

  // ---------------------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------------------
  wire wr_cmp_a = reg_wr && reg_addr == PWMFDT_CMP_A;
  wire wr_cmp_b = reg_wr && reg_addr == PWMFDT_CMP_B;
  wire wr_act_first = reg_wr && reg_addr == PWMFDT_ACT_FIRST;
  wire wr_act_second = reg_wr && reg_addr == PWMFDT_ACT_SECOND;
  wire wr_force_cfg = reg_wr && reg_addr == PWMFDT_FORCE_CFG;
  wire wr_force_now = reg_wr && reg_addr == PWMFDT_FORCE_NOW;
  wire wr_dt_cfg = reg_wr && reg_addr == PWMFDT_DT_CFG;
  wire wr_rise = reg_wr && reg_addr == PWMFDT_RISE_DLY;
  wire wr_fall = reg_wr && reg_addr == PWMFDT_FALL_DLY;

  // ---------------------------------------------------------------------------
  // timing events
  // ---------------------------------------------------------------------------
  wire ev_zero = timer_count == 16'h0000;
  wire ev_period = timer_count == timer_period_value;
  wire ev_a = timer_count == cmp_a_q;
  wire ev_b = timer_count == cmp_b_q;

  // each output walks its own action table off the shared compares A and B, so a
  // dead band can be placed by edge position alone
  wire [1:0] act_first = pick_act(act_first_q, timer_count_up, ev_zero, ev_period, ev_a, ev_b); // [RULE1] [RULE2]
  wire [1:0] act_second = pick_act(act_second_q, timer_count_up, ev_zero, ev_period, ev_a, ev_b); // [RULE3]

  // ---------------------------------------------------------------------------
  // software forcing
  // ---------------------------------------------------------------------------
  wire [1:0] held_en = force_cfg_q[PWMFDT_FC_HELD_EN +: 2]; // [RULE7]
  wire [1:0] held_lvl = force_cfg_q[PWMFDT_FC_HELD_LVL +: 2];
  wire [1:0] held_trig = force_cfg_q[PWMFDT_FC_HELD_TRIG +: 2];
  wire [1:0] once_lvl = force_cfg_q[PWMFDT_FC_ONCE_LVL +: 2];
  wire [1:0] once_hit = wr_force_now ? reg_wdata[1:0] : 2'b00;

  logic held_fire;
  always_comb begin
    case (held_trig)
      PWMFDT_TRIG_NOW: held_fire = 1'b1;
      PWMFDT_TRIG_UP_COUNT_ZERO_EVENT: held_fire = timer_count_up && ev_zero;
      PWMFDT_TRIG_UTEP: held_fire = timer_count_up && ev_period;
      PWMFDT_TRIG_DTEZ: held_fire = !timer_count_up && ev_zero;
      default: held_fire = 1'b0;
    endcase
  end

  // a held force arms on its trigger and lasts until its enable is cleared
  assign held_force_d = held_en & (held_force_q | {2{held_fire}}); // [RULE5] [RULE6] [RULE7]

  // held force beats a one-time force, which beats every timing event
  always_comb begin
    gen_first_d = apply_act(gen_first_q, act_first); // [RULE20]
    gen_second_d = apply_act(gen_second_q, act_second); // [RULE20]
    if (once_hit[0]) gen_first_d = once_lvl[0]; // [RULE4]
    if (once_hit[1]) gen_second_d = once_lvl[1]; // [RULE4]
    if (held_force_d[0]) gen_first_d = held_lvl[0]; // [RULE5]
    if (held_force_d[1]) gen_second_d = held_lvl[1]; // [RULE5]
  end

  // ---------------------------------------------------------------------------
  // dead time unit
  // ---------------------------------------------------------------------------
  wire [8:0] sw = dt_cfg_q[8:0]; // [RULE9]
  wire dly_tick = dt_cfg_q[PWMFDT_DELAY_CLOCK_SEL] ? timer_prescaled_clock : 1'b1; // [RULE17]

  // swaps act on the inputs; with them and the source selects at zero both delay paths see the first input
  wire in_first = sw[PWMFDT_SW_FIRST_SWAP] ? gen_second_q : gen_first_q;
  wire in_second = sw[PWMFDT_SW_SECOND_SWAP] ? gen_first_q : gen_second_q;
  wire rise_in = sw[PWMFDT_SW_RISE_SRC] ? in_second : in_first; // [RULE8] [RULE14]

  // rising edge path: high only once the input has stayed high for the count
  wire rise_done = rise_delay_count_q == 16'h0000 || rise_cnt_q >= rise_delay_count_q; // [RULE21]
  wire rise_raw = rise_in && rise_done; // [RULE16]

  // dual edge mode chains the fall delay behind the rise delay
  wire fall_src = sw[PWMFDT_SW_FALL_SRC] ? in_second : in_first; // [RULE14]
  wire fall_in = sw[PWMFDT_SW_DUAL_EDGE] ? rise_raw : fall_src; // [RULE8]
  wire fall_done = fall_delay_count_q == 16'h0000 || fall_cnt_q >= fall_delay_count_q; // [RULE21]
  wire fall_raw = fall_in || !fall_done; // [RULE16]

  assign rise_cnt_d = dly_next(rise_cnt_q, rise_in, dly_tick, rise_delay_count_q);
  assign fall_cnt_d = dly_next(fall_cnt_q, !fall_in, dly_tick, fall_delay_count_q);

  wire rise_path = rise_raw ^ sw[PWMFDT_SW_RISE_INV]; // [RULE11]
  wire fall_path = fall_raw ^ sw[PWMFDT_SW_FALL_INV]; // [RULE11]

  // bypasses pass the swapped inputs straight through; both set bypasses
  // the whole unit
  wire out_first = sw[PWMFDT_SW_FIRST_BYP] ? in_first : rise_path; // [RULE10] [RULE12] [RULE13] [RULE19]
  wire out_second = sw[PWMFDT_SW_SECOND_BYP] ? in_second : fall_path; // [RULE10] [RULE12] [RULE13] [RULE15]

  // ---------------------------------------------------------------------------
  // shadow update of delay counts
  // ---------------------------------------------------------------------------
  wire [1:0] upd_sel = dt_cfg_q[PWMFDT_DT_UPD +: 2];
  wire upd_now = upd_sel == PWMFDT_UPD_NOW ||
                 (upd_sel[0] && ev_zero) ||
                 (upd_sel[1] && ev_period); // [RULE18]

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    case (reg_addr)
      PWMFDT_CMP_A: rdata_d = cmp_a_q;
      PWMFDT_CMP_B: rdata_d = cmp_b_q;
      PWMFDT_ACT_FIRST: rdata_d = act_first_q;
      PWMFDT_ACT_SECOND: rdata_d = act_second_q;
      PWMFDT_FORCE_CFG: rdata_d = {8'h00, force_cfg_q};
      PWMFDT_DT_CFG: rdata_d = {4'h0, dt_cfg_q};
      PWMFDT_RISE_DLY: rdata_d = rise_shadow_q;
      PWMFDT_FALL_DLY: rdata_d = fall_shadow_q;
      PWMFDT_STATUS: rdata_d = {10'h000, held_force_q, pair_output_second, pair_output_first,
                                gen_second_q, gen_first_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // flip-flops
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a_q <= PWMFDT_CMP_RST;
      cmp_b_q <= PWMFDT_CMP_RST;
      act_first_q <= PWMFDT_ACT_RST;
      act_second_q <= PWMFDT_ACT_RST;
      force_cfg_q <= PWMFDT_FORCE_RST;
      dt_cfg_q <= PWMFDT_DT_CFG_RST;
    end else begin
      if (wr_cmp_a) cmp_a_q <= reg_wdata;
      if (wr_cmp_b) cmp_b_q <= reg_wdata;
      if (wr_act_first) act_first_q <= reg_wdata;
      if (wr_act_second) act_second_q <= reg_wdata;
      if (wr_force_cfg) force_cfg_q <= reg_wdata[7:0];
      if (wr_dt_cfg) dt_cfg_q <= reg_wdata[11:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_shadow_q <= PWMFDT_DLY_RST;
      fall_shadow_q <= PWMFDT_DLY_RST;
      rise_delay_count_q <= PWMFDT_DLY_RST;
      fall_delay_count_q <= PWMFDT_DLY_RST;
    end else begin
      if (wr_rise) rise_shadow_q <= reg_wdata;
      if (wr_fall) fall_shadow_q <= reg_wdata;
      if (upd_now) begin
        rise_delay_count_q <= rise_shadow_q; // [RULE18]
        fall_delay_count_q <= fall_shadow_q; // [RULE18]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_force_q <= 2'b00;
      gen_first_q <= 1'b0;
      gen_second_q <= 1'b0;
      rise_cnt_q <= 16'h0000;
      fall_cnt_q <= 16'h0000;
      pair_output_first <= 1'b0;
      pair_output_second <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      held_force_q <= held_force_d;
      gen_first_q <= gen_first_d;
      gen_second_q <= gen_second_d;
      rise_cnt_q <= rise_cnt_d;
      fall_cnt_q <= fall_cnt_d;
      pair_output_first <= out_first;
      pair_output_second <= out_second;
      reg_rdata <= reg_rd ? rdata_d : 16'h0000;
    end
  end

endmodule // pwmfdt_stage

// ---- include/pwmfdt_pkg.sv ----
// package: register map, field positions, reset values and encodings of the pwm force and dead time stage
package pwmfdt_pkg;

  // ---------------------------------------------------------------------------
  // register word addresses
  // ---------------------------------------------------------------------------
  localparam logic [3:0] PWMFDT_CMP_A = 4'h0;
  localparam logic [3:0] PWMFDT_CMP_B = 4'h1;
  localparam logic [3:0] PWMFDT_ACT_FIRST = 4'h2;
  localparam logic [3:0] PWMFDT_ACT_SECOND = 4'h3;
  localparam logic [3:0] PWMFDT_FORCE_CFG = 4'h4;
  localparam logic [3:0] PWMFDT_FORCE_NOW = 4'h5;
  localparam logic [3:0] PWMFDT_DT_CFG = 4'h6;
  localparam logic [3:0] PWMFDT_RISE_DLY = 4'h7;
  localparam logic [3:0] PWMFDT_FALL_DLY = 4'h8;
  localparam logic [3:0] PWMFDT_STATUS = 4'h9;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  // action register: two bits per event
  localparam int PWMFDT_ACT_UP_COUNT_ZERO_EVENT = 0;
  localparam int PWMFDT_ACT_UTEP = 2;
  localparam int PWMFDT_ACT_UTEA = 4;
  localparam int PWMFDT_ACT_UTEB = 6;
  localparam int PWMFDT_ACT_DTEZ = 8;
  localparam int PWMFDT_ACT_DTEP = 10;
  localparam int PWMFDT_ACT_DTEA = 12;
  localparam int PWMFDT_ACT_DTEB = 14;
  // force configuration
  localparam int PWMFDT_FC_HELD_EN = 0;
  localparam int PWMFDT_FC_HELD_LVL = 2;
  localparam int PWMFDT_FC_HELD_TRIG = 4;
  localparam int PWMFDT_FC_ONCE_LVL = 6;
  // dead time configuration: switches in bits 8:0
  localparam int PWMFDT_SW_SECOND_BYP = 0;
  localparam int PWMFDT_SW_FIRST_BYP = 1;
  localparam int PWMFDT_SW_RISE_INV = 2;
  localparam int PWMFDT_SW_FALL_INV = 3;
  localparam int PWMFDT_SW_RISE_SRC = 4;
  localparam int PWMFDT_SW_FALL_SRC = 5;
  localparam int PWMFDT_SW_FIRST_SWAP = 6;
  localparam int PWMFDT_SW_SECOND_SWAP = 7;
  localparam int PWMFDT_SW_DUAL_EDGE = 8;
  localparam int PWMFDT_DELAY_CLOCK_SEL = 9;
  localparam int PWMFDT_DT_UPD = 10;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] PWMFDT_CMP_RST = 16'h0000;
  localparam logic [15:0] PWMFDT_ACT_RST = 16'h0000;
  localparam logic [7:0] PWMFDT_FORCE_RST = 8'h00;
  // both output bypasses set: the stage passes through after reset
  localparam logic [11:0] PWMFDT_DT_CFG_RST = 12'h003;
  localparam logic [15:0] PWMFDT_DLY_RST = 16'h0000;

  // ---------------------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {PWMFDT_ACT_NONE, PWMFDT_ACT_LOW, PWMFDT_ACT_HIGH, PWMFDT_ACT_TOGGLE} pwmfdt_act_t;
  typedef enum logic [1:0] {PWMFDT_TRIG_NOW, PWMFDT_TRIG_UP_COUNT_ZERO_EVENT, PWMFDT_TRIG_UTEP, PWMFDT_TRIG_DTEZ} pwmfdt_trig_t;
  // shadow update point: 0 at once, 1 at zero, 2 at period, 3 at either
  localparam logic [1:0] PWMFDT_UPD_NOW = 2'h0;
  localparam logic [1:0] PWMFDT_UPD_ZERO = 2'h1;
  localparam logic [1:0] PWMFDT_UPD_PERIOD = 2'h2;

endpackage

// ---- bench/pwmfdt_timer_model.sv ----
// timer model: counts up or up-down between zero and a period and ticks a prescaled clock
`timescale 1ns/10ps
module pwmfdt_timer_model #(
  parameter int PRE = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic up_down,
  input wire logic [15:0] period,
  output logic [15:0] timer_count,
  output logic timer_count_up,
  output logic timer_prescaled_clock
);
  logic [7:0] pre_q;
  // the tick is free running, so its phase against any output edge is arbitrary
  assign timer_prescaled_clock = (pre_q == 8'(PRE - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= 16'h0000;
      timer_count_up <= 1'b1;
      pre_q <= 8'h00;
    end else begin
      pre_q <= timer_prescaled_clock ? 8'h00 : pre_q + 8'h01;
      if (!up_down) begin
        timer_count_up <= 1'b1;
        timer_count <= (timer_count >= period) ? 16'h0000 : timer_count + 16'h0001;
      end else if (timer_count_up) begin
        // turns at the period so only the falling-direction period event occurs
        timer_count <= timer_count + 16'h0001;
        timer_count_up <= (timer_count + 16'h0001) < period;
      end else begin
        timer_count <= timer_count - 16'h0001;
        timer_count_up <= (timer_count == 16'h0001);
      end
    end
  end
endmodule // pwmfdt_timer_model

// ---- bench/pwmfdt_stage_sva.sv ----
// checker: bus and forcing relations seen at the pins of the pwm stage
`timescale 1ns/10ps
module pwmfdt_stage_sva
  import pwmfdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] timer_count,
  input wire logic timer_count_up,
  input wire logic [15:0] timer_period_value,
  input wire logic timer_prescaled_clock,
  input wire logic pair_output_first,
  input wire logic pair_output_second
);
  // ---------------------------------------------------------------------------
  // mirrors of the set-up written by software
  // ---------------------------------------------------------------------------
  logic [15:0] cmp_a_q;
  logic [7:0] fc_q;
  logic [11:0] dt_q;
  logic [2:0] quiet_q;
  wire logic cfg_wr = reg_wr && (reg_addr == PWMFDT_FORCE_CFG || reg_addr == PWMFDT_DT_CFG);
  wire logic bypassed = (dt_q[8:0] == 9'h003) && (quiet_q >= 3'h4);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a_q <= PWMFDT_CMP_RST;
      fc_q <= PWMFDT_FORCE_RST;
      dt_q <= PWMFDT_DT_CFG_RST;
      quiet_q <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == PWMFDT_CMP_A) cmp_a_q <= reg_wdata;
      if (reg_wr && reg_addr == PWMFDT_FORCE_CFG) fc_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == PWMFDT_DT_CFG) dt_q <= reg_wdata[11:0];
      // saturating: only "long enough since the last set-up change" matters
      quiet_q <= cfg_wr ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  reset_quiet_a: assert property ($rose(rst_n) |-> reg_rdata == 16'h0000 && !pair_output_first
    && !pair_output_second) else $error("outputs not idle after reset");
  rdata_pulse_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) > 4'h9 |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  force_now_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == PWMFDT_FORCE_NOW |-> reg_rdata == 16'h0000)
    else $error("force trigger register read not zero");
  cmpa_readback_a: assert property ($past(reg_rd) && $past(reg_addr) == PWMFDT_CMP_A |-> reg_rdata == cmp_a_q)
    else $error("compare read back differs");
  dtcfg_readback_a: assert property ($past(reg_rd) && $past(reg_addr) == PWMFDT_DT_CFG
    |-> reg_rdata == {4'h0, dt_q}) else $error("dead time switches read back differ");
  held_first_a: assert property (bypassed && fc_q[0] && fc_q[5:4] == 2'h0
    |-> pair_output_first == fc_q[2]) else $error("held level lost on first output");
  held_second_a: assert property (bypassed && fc_q[1] && fc_q[5:4] == 2'h0
    |-> pair_output_second == fc_q[3]) else $error("held level lost on second output");
endmodule // pwmfdt_stage_sva
bind pwmfdt_stage pwmfdt_stage_sva i_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_count(timer_count),
  .timer_count_up(timer_count_up), .timer_period_value(timer_period_value),
  .timer_prescaled_clock(timer_prescaled_clock), .pair_output_first(pair_output_first),
  .pair_output_second(pair_output_second));

// ---- bench/tb_top.sv ----
// testbench: register access, generator actions, forcing and dead time modes of the pwm stage
`timescale 1ns/10ps
module tb_top;
  import pwmfdt_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, mode, count_up, tick, o1, o2;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, count, period;
  int errors = 0;
  int n_tests = 0;
  // {switches, first delay, first invert, second width, second delay, second invert}
  int t [7][6] = '{'{3, 0, 0, 0, 0, 0}, '{8, -3, 0, 10, 2, 1}, '{4, -3, 1, 10, 2, 0}, '{0, -3, 0, 10, 2, 0},
    '{12, -3, 1, 10, 2, 1}, '{2, 0, 0, 10, 2, 0}, '{1, -3, 0, 0, 0, 0}};
  pwmfdt_timer_model #(.PRE(4)) i_timer (.clk(clk), .rst_n(rst_n), .up_down(mode), .period(period),
    .timer_count(count), .timer_count_up(count_up), .timer_prescaled_clock(tick));
  pwmfdt_stage i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_count(count), .timer_count_up(count_up),
    .timer_period_value(period), .timer_prescaled_clock(tick), .pair_output_first(o1), .pair_output_second(o2));
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // high cycles over two periods of 31 for a 10-cycle pulse moved by an edge delay
  function automatic logic [15:0] hi(int w, int d, int inv);
    int x;
    x = w + d;
    if (inv != 0) x = 31 - x;
    return 16'(2 * x);
  endfunction
  task automatic final_report;
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic meas(input int settle, input int n, output logic [15:0] h1, output logic [15:0] h2);
    h1 = 16'h0000;
    h2 = 16'h0000;
    repeat (settle) @(posedge clk);
    repeat (n) begin
      @(posedge clk);
      #1 h1 += 16'(o1);
      h2 += 16'(o2);
    end
  endtask
  // ---------------------------------------------------------------------------
  // clock, watchdog and tests
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000 errors++;
    final_report();
  end
  initial begin
    logic [15:0] v, h1, h2;
    void'($urandom(29787));
    {rst_n, reg_wr, reg_rd, mode, reg_addr, reg_wdata} = '0;
    period = 16'd20;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(PWMFDT_DT_CFG, v); chk(v, {4'h0, PWMFDT_DT_CFG_RST});
    rd(PWMFDT_FORCE_CFG, v); chk(v, 16'h0000);
    rd(PWMFDT_FORCE_NOW, v); chk(v, 16'h0000);
    for (int a = 10; a < 16; a++) begin
      wr(a[3:0], 16'hffff); rd(a[3:0], v); chk(v, 16'h0000);
    end
    repeat (8) begin
      v = 16'($urandom);
      wr(PWMFDT_CMP_A, v); rd(PWMFDT_CMP_A, h1); chk(h1, v);
    end
    // pulse placed between the two compares while counting up
    wr(PWMFDT_CMP_A, 16'd5); wr(PWMFDT_CMP_B, 16'd12); wr(PWMFDT_ACT_FIRST, 16'h0060);
    meas(25, 42, h1, h2); chk(h1, 16'd14);
    // symmetric and complementary edges while counting up and down
    mode <= 1'b1;
    wr(PWMFDT_CMP_A, 16'd8); wr(PWMFDT_ACT_FIRST, 16'h1020); wr(PWMFDT_ACT_SECOND, 16'h8040);
    meas(50, 80, h1, h2); chk(h1, 16'd48); chk(h2, 16'd48);
    // toggle at zero, then held forcing per output
    mode <= 1'b0;
    wr(PWMFDT_ACT_FIRST, 16'h0003); wr(PWMFDT_ACT_SECOND, 16'h0003);
    meas(25, 42, h1, h2); chk(h1, 16'd21); chk(h2, 16'd21);
    wr(PWMFDT_FORCE_CFG, 16'h0015);
    meas(25, 42, h1, h2); chk(h1, 16'd42); chk(h2, 16'd21);
    wr(PWMFDT_FORCE_CFG, 16'h000b);
    meas(4, 42, h1, h2); chk(h1, 16'd0); chk(h2, 16'd42);
    wr(PWMFDT_FORCE_CFG, 16'h0000);
    meas(5, 42, h1, h2); chk(h1, 16'd21);
    // one-time force mid period, undone by the next zero event
    // second output cleared at zero so its level is known for the dead time rows
    wr(PWMFDT_ACT_FIRST, 16'h0002); wr(PWMFDT_ACT_SECOND, 16'h0001);
    repeat (25) @(posedge clk);
    for (int i = 0; i < 40 && count !== 16'd5; i++) @(posedge clk);
    wr(PWMFDT_FORCE_NOW, 16'h0001);
    repeat (3) @(posedge clk);
    #1 chk({15'h0, o1}, 16'h0000);
    repeat (20) @(posedge clk);
    #1 chk({15'h0, o1}, 16'h0001);
    // dead time modes on a 10-cycle pulse, rise delay 3, fall delay 2
    period <= 16'd30;
    wr(PWMFDT_CMP_B, 16'd15); wr(PWMFDT_CMP_A, 16'd5); wr(PWMFDT_ACT_FIRST, 16'h0060);
    wr(PWMFDT_RISE_DLY, 16'd3); wr(PWMFDT_FALL_DLY, 16'd2);
    for (int r = 0; r < 7; r++) begin
      wr(PWMFDT_DT_CFG, 16'(t[r][0])); rd(PWMFDT_DT_CFG, v); chk(v, 16'(t[r][0]));
      meas(40, 62, h1, h2);
      chk(h1, hi(10, t[r][1], t[r][2]));
      chk(h2, hi(t[r][3], t[r][4], t[r][5]));
    end
    wr(PWMFDT_RISE_DLY, 16'd0); wr(PWMFDT_FALL_DLY, 16'd0); wr(PWMFDT_DT_CFG, 16'h0008);
    meas(40, 62, h1, h2); chk(h1, hi(10, 0, 0)); chk(h2, hi(10, 0, 1));
    wr(PWMFDT_RISE_DLY, 16'd7); rd(PWMFDT_RISE_DLY, v); chk(v, 16'd7);
    // delay counted in prescaled ticks: four cycles each, phase unknown
    wr(PWMFDT_RISE_DLY, 16'd2); wr(PWMFDT_FALL_DLY, 16'd2); wr(PWMFDT_DT_CFG, 16'h0200);
    meas(40, 62, h1, h2);
    chk(16'(h1 >= 16'd2 && h1 <= 16'd12), 16'h0001);
    chk(16'(h2 >= 16'd28 && h2 <= 16'd38), 16'h0001);
    final_report();
  end
endmodule // tb_top
